// ### verilog/mss_pkg.sv
// Purpose: Constants and types for the marker state sequencer
// Assumes: 100 MHz system clock
// Notes: Register map is the sequencer's own, reached over AHB-Lite
package mss_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int CLK_MHZ = 100;
  localparam int BOOT_TIME_S = 60;
  localparam int WARMUP_TIME_S = 30;
  localparam int DEBOUNCE_TIME_US = 1000;
  localparam int BLINK_HALF_MS = 250;
  localparam longint BOOT_CYCLES = longint'(BOOT_TIME_S) * CLK_MHZ * 1000000;
  localparam longint WARMUP_CYCLES =
    longint'(WARMUP_TIME_S) * CLK_MHZ * 1000000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_MHZ;
  localparam int BLINK_CYCLES = BLINK_HALF_MS * CLK_MHZ * 1000;

  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ERROR_OFS = 8'h08;
  localparam logic [7:0] INPUTS_OFS = 8'h0C;

  // Control fields
  localparam int CTRL_ENGINE_LOADED_BIT = 0;
  localparam int CTRL_AIM_REQ_BIT = 1;
  localparam int CTRL_FOCUS_REQ_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Error fields
  localparam int ERR_LOCK_BIT = 0;
  localparam int ERR_PRESENCE_BIT = 1;
  localparam int ERR_TEMP_BIT = 2;
  localparam int ERR_OSC_BIT = 3;
  localparam int ERR_ORDER_BIT = 4;

  // ==========================================================
  // States
  // ==========================================================
  typedef enum logic [2:0] {
    MSS_BOOT = 3'b000,
    MSS_WAIT = 3'b001,
    MSS_WARMUP = 3'b010,
    MSS_STANDBY = 3'b011,
    MSS_READY = 3'b100,
    MSS_ERROR = 3'b101,
    MSS_WARN = 3'b110
  } mss_state_t;

endpackage

// ### verilog/mss_sequencer.sv
// Purpose: System state sequencer of a laser marking station
// Assumes: Inputs synchronous-ish; fault inputs are levels from the source
// Notes: Error and warning states are left only as the rules allow
//
// Functional notes
// - Boot state, blinking, until engine loads cleanly
// - Wait-for-start: no emission, no aiming, steady
// - Warm-up runs its process, indicator blinking
// - Standby: aim and focus allowed, no emission
// - Emission permitted only in ready, steady
// - Any blocking error enters error, blinking
// - Lock active flags error; clear after off, restart
// - Presence low flags error; clear after high, restart
// - Temperature fault latched until full restart
// - Oscillator fault latched until full restart
// - Wrong turn-on order gives blinking warning state
// - Control from panel selectors or connector lines
// - Connector: low boot/wait, key warm/standby, all ready
// - Boot 60 s, warm-up 30 s, enables give ready
//
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps

// ============================================================
// Input conditioner: two-flop sync plus debounce
// ============================================================
module mss_debounce #(
  parameter int COUNT = 100000
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic raw,
  output logic clean
);
  logic sync1_reg;
  logic sync2_reg;
  logic [31:0] cnt_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Level must hold for COUNT cycles before it is accepted
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= 32'h0;
      clean <= 1'b0;
    end
    else if (sync2_reg == clean)
      cnt_reg <= 32'h0;
    else if (cnt_reg >= 32'(COUNT - 1))
    begin
      cnt_reg <= 32'h0;
      clean <= sync2_reg;
    end
    else
      cnt_reg <= cnt_reg + 32'h1;
  end
endmodule

// ============================================================
// Top: sequencer with AHB-Lite register slave
// ============================================================
module mss_sequencer #(
  parameter longint BOOT_CYCLES = mss_pkg::BOOT_CYCLES,
  parameter longint WARMUP_CYCLES = mss_pkg::WARMUP_CYCLES,
  parameter int DEBOUNCE_CYCLES = mss_pkg::DEBOUNCE_CYCLES,
  parameter int BLINK_CYCLES = mss_pkg::BLINK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_key_input,
  input wire logic external_enable_first,
  input wire logic external_enable_second,
  input wire logic key_selector_on,
  input wire logic enable_selector_on,
  input wire logic connector_present_input,
  input wire logic safety_lock_function,
  input wire logic temperature_fault,
  input wire logic oscillator_fault,
  output logic emission_allowed,
  output logic aim_beam_on,
  output logic focus_beam_on,
  output logic warmup_active,
  output logic status_led,
  output logic [2:0] state_out
);

  logic key_c;
  logic ena_c;
  logic enb_c;
  logic ksel_c;
  logic esel_c;
  logic pres_c;
  logic lock_c;
  logic [2:0] ctrl_reg;
  logic [4:0] err_reg;
  logic [63:0] timer_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic restart_armed_reg;
  mss_pkg::mss_state_t state_reg;
  mss_pkg::mss_state_t state_next;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic key_eff;
  logic en_eff;
  logic order_bad;
  logic fatal_err;

  // ==========================================================
  // Input conditioning
  // ==========================================================
  logic [6:0] raw_in;
  logic [6:0] clean_in;
  logic absent_c;
  // Presence is conditioned as absence: the debouncer's reset level then
  // means present, so a reset never raises a false presence error
  assign raw_in = {external_key_input, external_enable_first,
                   external_enable_second, key_selector_on,
                   enable_selector_on, ~connector_present_input,
                   safety_lock_function};
  assign {key_c, ena_c, enb_c, ksel_c, esel_c, absent_c, lock_c} = clean_in;
  assign pres_c = ~absent_c;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++)
    begin : g_deb
      mss_debounce #(.COUNT(DEBOUNCE_CYCLES)) u_deb (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(raw_in[gi]),
        .clean(clean_in[gi])
      );
    end
  endgenerate

  // Key and enable are each the AND of panel and connector paths:
  // the unused path is held high by the outside party.
  assign key_eff = key_c & ksel_c;
  assign en_eff = ena_c & enb_c & esel_c;
  // Enable ahead of key, or one enable line without the other
  assign order_bad = (en_eff & ~key_eff) | (ena_c ^ enb_c);
  assign fatal_err = err_reg[mss_pkg::ERR_TEMP_BIT]
                   | err_reg[mss_pkg::ERR_OSC_BIT];

  // ==========================================================
  // Error flags
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      err_reg <= 5'h0;
    else
    begin
      // Only hresetn clears temperature and oscillator faults
      if (temperature_fault)
        err_reg[mss_pkg::ERR_TEMP_BIT] <= 1'b1;
      if (oscillator_fault)
        err_reg[mss_pkg::ERR_OSC_BIT] <= 1'b1;
      if (lock_c)
        err_reg[mss_pkg::ERR_LOCK_BIT] <= 1'b1;
      else if (restart_armed_reg && !key_eff && !en_eff)
        err_reg[mss_pkg::ERR_LOCK_BIT] <= 1'b0;
      if (!pres_c)
        err_reg[mss_pkg::ERR_PRESENCE_BIT] <= 1'b1;
      else if (restart_armed_reg && !key_eff && !en_eff)
        err_reg[mss_pkg::ERR_PRESENCE_BIT] <= 1'b0;
      if (state_next == mss_pkg::MSS_WARN)
        err_reg[mss_pkg::ERR_ORDER_BIT] <= 1'b1;
      else if (state_next == mss_pkg::MSS_WAIT)
        err_reg[mss_pkg::ERR_ORDER_BIT] <= 1'b0;
    end
  end

  // Restart is armed once lock and presence conditions are good
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      restart_armed_reg <= 1'b0;
    else
      restart_armed_reg <= !lock_c && pres_c;
  end

  // ==========================================================
  // State machine
  // ==========================================================
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      mss_pkg::MSS_BOOT:
        if (err_reg[3:0] != 4'h0 || lock_c || !pres_c)
          state_next = mss_pkg::MSS_ERROR;
        else if (ctrl_reg[mss_pkg::CTRL_ENGINE_LOADED_BIT]
                 && timer_reg >= 64'(BOOT_CYCLES))
          state_next = mss_pkg::MSS_WAIT;
      mss_pkg::MSS_WAIT:
        if (order_bad)
          state_next = mss_pkg::MSS_WARN;
        else if (key_eff)
          state_next = mss_pkg::MSS_WARMUP;
      mss_pkg::MSS_WARMUP:
        if (en_eff || (ena_c ^ enb_c))
          state_next = mss_pkg::MSS_WARN;
        else if (!key_eff)
          state_next = mss_pkg::MSS_WAIT;
        else if (timer_reg >= 64'(WARMUP_CYCLES))
          state_next = mss_pkg::MSS_STANDBY;
      mss_pkg::MSS_STANDBY:
        if (!key_eff || (ena_c ^ enb_c))
          state_next = key_eff ? mss_pkg::MSS_WARN : mss_pkg::MSS_WAIT;
        else if (en_eff)
          state_next = mss_pkg::MSS_READY;
      mss_pkg::MSS_READY:
        if (!key_eff)
          state_next = mss_pkg::MSS_WAIT;
        else if (!en_eff)
          state_next = mss_pkg::MSS_STANDBY;
      mss_pkg::MSS_ERROR:
        // Lock errors leave via a fresh turn-on from all-low inputs
        if (err_reg[3:0] == 4'h0 && !key_eff && !en_eff)
          state_next = mss_pkg::MSS_WAIT;
      mss_pkg::MSS_WARN:
        if (!key_eff && !ena_c && !enb_c)
          state_next = mss_pkg::MSS_WAIT;
      default:
        state_next = mss_pkg::MSS_BOOT;
    endcase
    // Faults outside boot override any normal transition
    if (state_reg != mss_pkg::MSS_BOOT
        && (fatal_err || lock_c || !pres_c
            || err_reg[1:0] != 2'h0))
      state_next = mss_pkg::MSS_ERROR;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= mss_pkg::MSS_BOOT;
    else
      state_reg <= state_next;
  end

  // Timer restarts on every state change
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_reg <= 64'h0;
    else if (state_next != state_reg)
      timer_reg <= 64'h0;
    else if (timer_reg != 64'hFFFFFFFFFFFFFFFF)
      timer_reg <= timer_reg + 64'h1;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end
    else if (blink_cnt_reg >= 32'(BLINK_CYCLES - 1))
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      emission_allowed <= 1'b0;
      aim_beam_on <= 1'b0;
      focus_beam_on <= 1'b0;
      warmup_active <= 1'b0;
      status_led <= 1'b0;
      state_out <= 3'h0;
    end
    else
    begin
      state_out <= state_next;
      emission_allowed <= state_next == mss_pkg::MSS_READY;
      // Aim and focus refused except in standby and ready
      aim_beam_on <= ctrl_reg[mss_pkg::CTRL_AIM_REQ_BIT]
                     && (state_next == mss_pkg::MSS_STANDBY
                         || state_next == mss_pkg::MSS_READY);
      focus_beam_on <= ctrl_reg[mss_pkg::CTRL_FOCUS_REQ_BIT]
                       && (state_next == mss_pkg::MSS_STANDBY
                           || state_next == mss_pkg::MSS_READY);
      warmup_active <= state_next == mss_pkg::MSS_WARMUP;
      case (state_next)
        mss_pkg::MSS_WAIT, mss_pkg::MSS_STANDBY, mss_pkg::MSS_READY:
          status_led <= 1'b1;
        default:
          status_led <= blink_reg;
      endcase
    end
  end

  // ==========================================================
  // AHB-Lite slave: zero wait states, always OKAY
  // ==========================================================
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= hsel && htrans[1] && hwrite;
      wr_addr_reg <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_reg <= mss_pkg::CTRL_RESET;
    else if (wr_pend_reg && wr_addr_reg == mss_pkg::CTRL_OFS)
      ctrl_reg <= hwdata[2:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (hready && hsel && htrans[1] && !hwrite)
      case (haddr[7:0])
        mss_pkg::CTRL_OFS: hrdata <= {29'h0, ctrl_reg};
        mss_pkg::STATUS_OFS: hrdata <= {29'h0, state_reg};
        mss_pkg::ERROR_OFS: hrdata <= {27'h0, err_reg};
        mss_pkg::INPUTS_OFS: hrdata <= {25'h0, clean_in[6:2], pres_c, lock_c};
        default: hrdata <= 32'h0;
      endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

// ### bench/mss_panel_model.sv
// Purpose: Front panel selectors and connector lines facing the sequencer
// Assumes: step 0 all off, 1 key, 2 key and enables, 3 enables only
// Notes: Outputs follow step at once; the bench moves step after an edge
`timescale 1ns/1ps

// ============================================================
// Panel and connector source
// ============================================================
module mss_panel_model (
  input wire logic [1:0] step,
  input wire logic panel,
  output logic key_line,
  output logic en_a_line,
  output logic en_b_line,
  output logic key_sel,
  output logic en_sel
);
  logic k;
  logic e;
  assign k = (step == 2'h1) || (step == 2'h2);
  assign e = step[1];
  // Panel use holds every connector line high
  assign key_line = panel ? 1'b1 : k;
  assign en_a_line = panel ? 1'b1 : e;
  assign en_b_line = panel ? 1'b1 : e;
  // Connector use parks both selectors in position 1
  assign key_sel = panel ? k : 1'b1;
  assign en_sel = panel ? e : 1'b1;
endmodule

// ### bench/mss_seq_asserts.sv
// Purpose: Port-level checks of the marker state sequencer
// Assumes: State codes BOOT 0 .. WARN 6, LED high when steady
// Notes: Bound to the top module from the bench
`timescale 1ns/1ps

// ============================================================
// Checker
// ============================================================
module mss_seq_checker #(
  parameter int BLINK_CYCLES = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic temperature_fault,
  input wire logic oscillator_fault,
  input wire logic emission_allowed,
  input wire logic aim_beam_on,
  input wire logic warmup_active,
  input wire logic status_led,
  input wire logic [2:0] state_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic led_q;
  logic [2:0] st_q;
  int led_cnt;
  int flt_cnt;
  // Cycles with LED and state unchanged; a stuck LED shows up here
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      led_q <= 1'b0;
      st_q <= 3'h0;
      led_cnt <= 0;
      flt_cnt <= 0;
    end
    else
    begin
      led_q <= status_led;
      st_q <= state_out;
      led_cnt <= (status_led != led_q || state_out != st_q) ? 0
                 : led_cnt + 1;
      if ((temperature_fault || oscillator_fault || flt_cnt != 0)
          && flt_cnt < 4)
        flt_cnt <= flt_cnt + 1;
    end
  end
  sequence s_fault;
    temperature_fault || oscillator_fault;
  endsequence
  sequence s_err;
    ##[1:3] state_out == 3'h5;
  endsequence
  emit_ready_a: assert property (
    emission_allowed == (state_out == 3'h4))
    else $error("emission flag outside ready");
  wait_dark_a: assert property (
    state_out == 3'h1 |-> !aim_beam_on)
    else $error("aiming beam in wait state");
  aim_gate_a: assert property (
    aim_beam_on |-> state_out inside {3'h3, 3'h4})
    else $error("aiming beam outside standby or ready");
  warm_flag_a: assert property (
    warmup_active == (state_out == 3'h2))
    else $error("warm-up flag wrong");
  steady_led_a: assert property (
    state_out inside {3'h1, 3'h3, 3'h4} |-> status_led)
    else $error("indicator not steady");
  // First cycle of a new state still carries the old state's count
  blink_led_a: assert property (
    state_out inside {3'h0, 3'h2, 3'h5, 3'h6} && state_out == st_q
    |-> led_cnt <= BLINK_CYCLES + 1)
    else $error("indicator not blinking");
  fault_entry_a: assert property (s_fault |-> s_err)
    else $error("fault did not reach error state");
  fault_hold_a: assert property (
    flt_cnt == 4 |-> state_out == 3'h5)
    else $error("error state left before restart");
  ready_entry_a: assert property (
    state_out == 3'h4 && $past(state_out) != 3'h4
    |-> $past(state_out) == 3'h3)
    else $error("ready entered not from standby");
  warm_entry_a: assert property (
    $rose(warmup_active) |-> $past(state_out) == 3'h1)
    else $error("warm-up entered not from wait");
endmodule

// ### bench/marker_state_sequencer_test.sv
// Purpose: Self-checking bench of the marker state sequencer
// Assumes: Short counts: boot 50, warm-up 30, debounce 4, blink 8
// Notes: Registers reached through single AHB-Lite word transfers
`timescale 1ns/1ps

`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("wrong value %s exp %0h got %0h", nm, e, g); \
    end \
  end

// ============================================================
// Bench top
// ============================================================
module marker_state_sequencer_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [1:0] step = 2'h0;
  logic panel = 1'b0;
  logic pres = 1'b1;
  logic lock = 1'b0;
  logic tflt = 1'b0;
  logic oflt = 1'b0;
  logic key, ena, enb, ksel, esel, emit, aim, focus, warm, led;
  logic [2:0] state_out;
  logic [31:0] r;
  int miscompares = 0;
  int checks_done = 0;
  int cyc = 0;
  mss_sequencer #(.BOOT_CYCLES(50), .WARMUP_CYCLES(30),
    .DEBOUNCE_CYCLES(4), .BLINK_CYCLES(8)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .external_key_input(key), .external_enable_first(ena),
    .external_enable_second(enb), .key_selector_on(ksel),
    .enable_selector_on(esel), .connector_present_input(pres),
    .safety_lock_function(lock), .temperature_fault(tflt),
    .oscillator_fault(oflt), .emission_allowed(emit),
    .aim_beam_on(aim), .focus_beam_on(focus), .warmup_active(warm),
    .status_led(led), .state_out(state_out));
  mss_panel_model mdl_u (.step(step), .panel(panel), .key_line(key),
    .en_a_line(ena), .en_b_line(enb), .key_sel(ksel), .en_sel(esel));
  initial
  begin
    forever #5 hclk = ~hclk;
  end
  // Hang guard: the whole run needs well under 3000 cycles
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_st(input logic [2:0] e);
    for (int i = 0; i < 300 && state_out !== e; i++)
      @(posedge hclk);
    `CHK("state", e, state_out)
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic t_boot();
    ahb(1'b1, 32'h0, 32'h1);
    repeat (25) @(posedge hclk);
    `CHK("boot hold", 3'h0, state_out)
    wait_st(mss_pkg::MSS_WAIT);
    ahb(1'b0, {24'h0, mss_pkg::STATUS_OFS}, 32'h0);
    `CHK("status reg", 32'h1, r)
    ahb(1'b0, {24'h0, mss_pkg::INPUTS_OFS}, 32'h0);
    `CHK("inputs reg", 32'h0000000E, r)
    ahb(1'b0, 32'h10, 32'h0);
    `CHK("unmapped", 32'h0, r)
    `CHK("okay resp", 1'b0, hresp)
    $display("boot test done");
  endtask
  task automatic t_run();
    step <= 2'h1;
    repeat (2) @(posedge hclk);
    step <= 2'h0;
    repeat (12) @(posedge hclk);
    `CHK("glitch", 3'h1, state_out)
    step <= 2'h1;
    wait_st(mss_pkg::MSS_WARMUP);
    repeat (15) @(posedge hclk);
    `CHK("warm-up", 1'b1, warm)
    wait_st(mss_pkg::MSS_STANDBY);
    ahb(1'b1, 32'h0, 32'h7);
    repeat (2) @(posedge hclk);
    `CHK("aim", 1'b1, aim)
    `CHK("focus", 1'b1, focus)
    `CHK("no emission", 1'b0, emit)
    step <= 2'h2;
    wait_st(mss_pkg::MSS_READY);
    `CHK("emission", 1'b1, emit)
    step <= 2'h0;
    wait_st(mss_pkg::MSS_WAIT);
    `CHK("aim in wait", 1'b0, aim)
    $display("run test done");
  endtask
  task automatic t_order();
    step <= 2'h3;
    wait_st(mss_pkg::MSS_WARN);
    ahb(1'b0, {24'h0, mss_pkg::ERROR_OFS}, 32'h0);
    `CHK("order flag", 1'b1, r[mss_pkg::ERR_ORDER_BIT])
    step <= 2'h0;
    wait_st(mss_pkg::MSS_WAIT);
    $display("order test done");
  endtask
  task automatic t_lock();
    for (int i = 0; i < 2; i++)
    begin
      lock <= (i == 0);
      pres <= (i == 0);
      wait_st(mss_pkg::MSS_ERROR);
      ahb(1'b0, {24'h0, mss_pkg::ERROR_OFS}, 32'h0);
      `CHK("lock flag", 1'b1, r[i])
      lock <= 1'b0;
      pres <= 1'b1;
      wait_st(mss_pkg::MSS_WAIT);
    end
    $display("lock test done");
  endtask
  task automatic t_panel();
    panel <= 1'b1;
    repeat (12) @(posedge hclk);
    `CHK("panel idle", 3'h1, state_out)
    step <= 2'h1;
    wait_st(mss_pkg::MSS_STANDBY);
    step <= 2'h2;
    wait_st(mss_pkg::MSS_READY);
    panel <= 1'b0;
    step <= 2'h0;
    wait_st(mss_pkg::MSS_WAIT);
    $display("panel test done");
  endtask
  task automatic t_fault();
    for (int i = 0; i < 2; i++)
    begin
      tflt <= (i == 0);
      oflt <= (i == 1);
      @(posedge hclk);
      tflt <= 1'b0;
      oflt <= 1'b0;
      wait_st(mss_pkg::MSS_ERROR);
      repeat (20) @(posedge hclk);
      `CHK("fault hold", 3'h5, state_out)
      ahb(1'b0, {24'h0, mss_pkg::ERROR_OFS}, 32'h0);
      `CHK("fault flag", 1'b1, r[i + 2])
      do_reset();
      `CHK("restart", 3'h0, state_out)
    end
    $display("fault test done");
  endtask
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_boot();
    t_run();
    t_order();
    t_lock();
    t_panel();
    t_fault();
    end_sim();
  end
endmodule

bind mss_sequencer mss_seq_checker #(.BLINK_CYCLES(BLINK_CYCLES)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .temperature_fault(temperature_fault),
  .oscillator_fault(oscillator_fault), .emission_allowed(emission_allowed),
  .aim_beam_on(aim_beam_on), .warmup_active(warmup_active),
  .status_led(status_led), .state_out(state_out));
